//--- hdl/gmc_pin_cell.sv
// One pin cell: selects peripheral or global control for a pin
`timescale 1ns/10ps
module gmc_pin_cell (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_override,
   input wire logic i_glb_oe,
   input wire logic i_glb_od,
   input wire logic i_glb_value,
   input wire logic i_per_out,
   input wire logic i_per_oe_n,
   input wire logic i_pin_in,
   output logic o_pin_out,
   output logic o_pin_oe_n,
   output logic o_level
);
   logic next_pin_out;
   logic next_pin_oe_n;

   // Owner select; open drain only ever drives low, so out stays 0
   always_comb begin
      if (!i_override) begin
         next_pin_out = i_per_out;
         next_pin_oe_n = i_per_oe_n;
      end else if (!i_glb_oe) begin
         next_pin_out = 1'b0;
         next_pin_oe_n = 1'b1;
      end else if (i_glb_od) begin
         next_pin_out = 1'b0;
         next_pin_oe_n = i_glb_value;
      end else begin
         next_pin_out = i_glb_value;
         next_pin_oe_n = 1'b0;
      end
   end

   // Register pin drive and input level
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_pin_out <= 1'b0;
         o_pin_oe_n <= 1'b1;
         o_level <= 1'b0;
      end else begin
         o_pin_out <= next_pin_out;
         o_pin_oe_n <= next_pin_oe_n;
         o_level <= i_pin_in;
      end
   end
endmodule : gmc_pin_cell

//--- hdl/gmc_pkg.sv
// Package of constants for the global I/O and misc control block
package gmc_pkg;
   // ******************************************************
   // Sizes
   // ******************************************************
   localparam int NUM_PINS = 30;
   localparam int PWM_BITS = 8;

   // ******************************************************
   // Register offsets (byte addresses, word aligned)
   // ******************************************************
   localparam logic [7:0] ADDR_PIN_OVERRIDE = 8'h00;
   localparam logic [7:0] ADDR_PIN_OE = 8'h04;
   localparam logic [7:0] ADDR_PIN_OPEN_DRAIN = 8'h08;
   localparam logic [7:0] ADDR_PIN_VALUE = 8'h0C;
   localparam logic [7:0] ADDR_PIN_READ = 8'h10;
   localparam logic [7:0] ADDR_PACKAGE_TYPE = 8'h14;
   localparam logic [7:0] ADDR_TEMP_CTRL = 8'h18;
   localparam logic [7:0] ADDR_SHARE_CTRL = 8'h1C;
   localparam logic [7:0] ADDR_FACTORY_TEMP = 8'h20;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
   localparam logic [7:0] ADDR_IO_MUX = 8'h2C;

   // ******************************************************
   // Field positions of the share control register
   // ******************************************************
   localparam int SHARE_MODE_LSB = 0;
   localparam int SHARE_TEST_LSB = 2;
   localparam int SHARE_PERIOD_LSB = 8;
   localparam int SHARE_DUTY_LSB = 16;

   // ******************************************************
   // Reset values and codes
   // ******************************************************
   localparam logic [1:0] PACKAGE_TYPE_RESET = 2'h0;
   localparam logic [29:0] PIN_RESET = 30'h0;
   localparam logic [1:0] SHARE_OFF = 2'h0;
   localparam logic [1:0] SHARE_PWM_BUS = 2'h1;
   localparam logic [1:0] SHARE_SLAVE = 2'h2;
   localparam logic [1:0] SHARE_ANALOG = 2'h3;
   localparam logic [7:0] SHARE_PERIOD_RESET = 8'hFF;
   localparam logic [7:0] SHARE_DUTY_RESET = 8'h00;
   localparam logic [11:0] FACTORY_TEMP_DEFAULT = 12'h800;
   localparam logic [31:0] IO_MUX_RESET = 32'h0;
   localparam int IRQ_BROWNOUT = 0;
endpackage : gmc_pkg

//--- hdl/gmc_share_pwm.sv
// 8-bit PWM current source for the current share bus
`timescale 1ns/10ps
module gmc_share_pwm (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_active,
   input wire logic [7:0] i_period,
   input wire logic [7:0] i_duty,
   output logic o_pwm
);
   logic [7:0] count;
   logic [7:0] next_count;
   logic next_pwm;

   // Counts 0..period; high while count below duty
   always_comb begin
      if (!i_active || count >= i_period) begin
         next_count = 8'h00;
      end else begin
         next_count = 8'(count + 8'h01);
      end
      next_pwm = i_active && (count < i_duty);
   end

   // Registered output, so no decode glitch reaches the share bus
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         count <= 8'h00;
         o_pwm <= 1'b0;
      end else begin
         count <= next_count;
         o_pwm <= next_pwm;
      end
   end
endmodule : gmc_share_pwm

//--- hdl/gmc_top.sv
// Global I/O and miscellaneous control unit: registers, pins, share logic
`timescale 1ns/10ps

// Overview of operation
// RL1 - Override bit zero keeps peripheral control, one gives global control; reset clear
// RL2 - Thirty pins, one bit each, fixed bit to pin mapping
// RL3 - Supply, ground, analog and reset pins are never general purpose pins
// RL4 - Output enable register sets each global pin as input or output
// RL5 - Read register returns the level of each input pin
// RL6 - Value register sets the driven level of each output pin
// RL7 - Per-pin drive choice: open drain drives only low, else push-pull
// RL8 - Two-bit package type field readable by firmware
// RL9 - Brownout sets a pollable flag, optionally raising an interrupt
// RL10 - Temperature sensor disabled at reset, firmware enables or disables it
// RL11 - Share mode 00/10 off, 01 PWM bus sw1, 11 analog sw2; test field 00
// RL12 - Share control sets PWM period, duty and both switch states
// RL13 - I/O mux control selects one function per shared physical pin
// RL14 - Firmware should not overwrite the factory temperature count
// RL15 - Clear override makes global settings ineffective; peripheral drives the pin
module gmc_top (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_write,
   input wire logic i_read,
   output logic [31:0] o_rdata,
   input wire logic [29:0] i_per_out,
   input wire logic [29:0] i_per_oe_n,
   input wire logic [29:0] i_pin_in,
   output logic [29:0] o_pin_out,
   output logic [29:0] o_pin_oe_n,
   output logic [29:0] o_per_in,
   input wire logic i_brownout,
   output logic o_irq,
   output logic o_temp_sensor_en,
   output logic o_share_switch_one,
   output logic o_share_switch_two,
   output logic o_share_pwm_output,
   output logic [31:0] o_io_mux_sel
);
   // ******************************************************
   // Register state
   // ******************************************************
   logic [29:0] pin_override_register;
   logic [29:0] pin_oe;
   logic [29:0] pin_open_drain;
   logic [29:0] pin_value;
   logic [1:0] package_type_field;
   logic temp_en;
   logic [1:0] share_mode;
   logic [1:0] share_test;
   logic [7:0] share_period;
   logic [7:0] share_duty;
   logic [11:0] factory_temp_count;
   logic irq_status;
   logic irq_mask;
   logic [31:0] io_mux;
   logic brownout_d;
   logic [29:0] pin_level;
   logic [29:0] next_pin_override_register;
   logic [29:0] next_pin_oe;
   logic [29:0] next_pin_open_drain;
   logic [29:0] next_pin_value;
   logic [1:0] next_package_type_field;
   logic next_temp_en;
   logic [1:0] next_share_mode;
   logic [1:0] next_share_test;
   logic [7:0] next_share_period;
   logic [7:0] next_share_duty;
   logic [11:0] next_factory_temp_count;
   logic next_irq_status;
   logic next_irq_mask;
   logic [31:0] next_io_mux;
   logic [31:0] next_rdata;
   logic next_irq;
   logic next_sw1;
   logic next_sw2;
   logic pwm_active;

   // ******************************************************
   // Pin configuration writes
   // ******************************************************
   // Whole-word writes; the port has no byte enables
   always_comb begin
      next_pin_override_register = pin_override_register;
      next_pin_oe = pin_oe;
      next_pin_open_drain = pin_open_drain;
      next_pin_value = pin_value;
      if (i_write) begin
         case (i_addr)
            gmc_pkg::ADDR_PIN_OVERRIDE: next_pin_override_register = i_wdata[29:0]; // RL1
            gmc_pkg::ADDR_PIN_OE: next_pin_oe = i_wdata[29:0]; // RL4
            gmc_pkg::ADDR_PIN_OPEN_DRAIN: next_pin_open_drain = i_wdata[29:0]; // RL7
            gmc_pkg::ADDR_PIN_VALUE: next_pin_value = i_wdata[29:0]; // RL6
            default: ;
         endcase
      end
   end

   // ******************************************************
   // Control register writes
   // ******************************************************
   // Test field is stored and read back but drives nothing
   always_comb begin
      next_package_type_field = package_type_field;
      next_temp_en = temp_en;
      next_share_mode = share_mode;
      next_share_test = share_test;
      next_share_period = share_period;
      next_share_duty = share_duty;
      next_factory_temp_count = factory_temp_count;
      next_io_mux = io_mux;
      if (i_write) begin
         case (i_addr)
            gmc_pkg::ADDR_PACKAGE_TYPE: next_package_type_field = i_wdata[1:0]; // RL8
            gmc_pkg::ADDR_TEMP_CTRL: next_temp_en = i_wdata[0]; // RL10
            gmc_pkg::ADDR_SHARE_CTRL: begin
               next_share_mode = i_wdata[gmc_pkg::SHARE_MODE_LSB +: 2]; // RL11
               next_share_test = i_wdata[gmc_pkg::SHARE_TEST_LSB +: 2];
               next_share_period = i_wdata[gmc_pkg::SHARE_PERIOD_LSB +: 8]; // RL12
               next_share_duty = i_wdata[gmc_pkg::SHARE_DUTY_LSB +: 8]; // RL12
            end
            // Writable only because trim flow needs it; firmware leaves it
            gmc_pkg::ADDR_FACTORY_TEMP: next_factory_temp_count = i_wdata[11:0]; // RL14
            gmc_pkg::ADDR_IO_MUX: next_io_mux = i_wdata; // RL13
            default: ;
         endcase
      end
   end

   // ******************************************************
   // Interrupt status and mask
   // ******************************************************
   // Rising brownout sets flag; set wins over a same-cycle clear
   always_comb begin
      next_irq_status = irq_status;
      next_irq_mask = irq_mask;
      if (i_write && i_addr == gmc_pkg::ADDR_IRQ_STATUS) begin
         if (i_wdata[gmc_pkg::IRQ_BROWNOUT]) begin
            next_irq_status = 1'b0; // Write one to clear
         end
      end
      if (i_write && i_addr == gmc_pkg::ADDR_IRQ_MASK) begin
         next_irq_mask = i_wdata[gmc_pkg::IRQ_BROWNOUT];
      end
      if (i_brownout && !brownout_d) begin
         next_irq_status = 1'b1; // RL9
      end
   end

   // ******************************************************
   // Read mux
   // ******************************************************
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (i_read) begin
         case (i_addr)
            gmc_pkg::ADDR_PIN_OVERRIDE: next_rdata = {2'h0, pin_override_register};
            gmc_pkg::ADDR_PIN_OE: next_rdata = {2'h0, pin_oe};
            gmc_pkg::ADDR_PIN_OPEN_DRAIN: next_rdata = {2'h0, pin_open_drain};
            gmc_pkg::ADDR_PIN_VALUE: next_rdata = {2'h0, pin_value};
            gmc_pkg::ADDR_PIN_READ: next_rdata = {2'h0, pin_level}; // RL5
            gmc_pkg::ADDR_PACKAGE_TYPE: next_rdata = {30'h0, package_type_field}; // RL8
            gmc_pkg::ADDR_TEMP_CTRL: next_rdata = {31'h0, temp_en};
            gmc_pkg::ADDR_SHARE_CTRL:
               next_rdata = {8'h00, share_duty, share_period, 4'h0, share_test, share_mode};
            gmc_pkg::ADDR_FACTORY_TEMP: next_rdata = {20'h0, factory_temp_count};
            gmc_pkg::ADDR_IRQ_STATUS: next_rdata = {31'h0, irq_status}; // RL9
            gmc_pkg::ADDR_IRQ_MASK: next_rdata = {31'h0, irq_mask};
            gmc_pkg::ADDR_IO_MUX: next_rdata = io_mux;
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // ******************************************************
   // Share switch decode and interrupt level
   // ******************************************************
   // Mode decode; 00 and 10 leave both switches open
   always_comb begin
      next_sw1 = (share_mode == gmc_pkg::SHARE_PWM_BUS); // RL11
      next_sw2 = (share_mode == gmc_pkg::SHARE_ANALOG); // RL11
      next_irq = irq_status && irq_mask;
   end

   assign pwm_active = (share_mode == gmc_pkg::SHARE_PWM_BUS); // RL11

   // ******************************************************
   // Registers
   // ******************************************************
   // Pin configuration; every pin starts under peripheral control
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         pin_override_register <= gmc_pkg::PIN_RESET; // RL1
         pin_oe <= gmc_pkg::PIN_RESET;
         pin_open_drain <= gmc_pkg::PIN_RESET;
         pin_value <= gmc_pkg::PIN_RESET;
      end else begin
         pin_override_register <= next_pin_override_register;
         pin_oe <= next_pin_oe;
         pin_open_drain <= next_pin_open_drain;
         pin_value <= next_pin_value;
      end
   end

   // ******************************************************
   // Control registers
   // ******************************************************
   // Sensor stays off until firmware turns it on
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         package_type_field <= gmc_pkg::PACKAGE_TYPE_RESET;
         temp_en <= 1'b0; // RL10
         share_mode <= gmc_pkg::SHARE_OFF;
         share_test <= 2'h0;
         share_period <= gmc_pkg::SHARE_PERIOD_RESET;
         share_duty <= gmc_pkg::SHARE_DUTY_RESET;
         factory_temp_count <= gmc_pkg::FACTORY_TEMP_DEFAULT;
         io_mux <= gmc_pkg::IO_MUX_RESET;
      end else begin
         package_type_field <= next_package_type_field;
         temp_en <= next_temp_en;
         share_mode <= next_share_mode;
         share_test <= next_share_test;
         share_period <= next_share_period;
         share_duty <= next_share_duty;
         factory_temp_count <= next_factory_temp_count;
         io_mux <= next_io_mux;
      end
   end

   // ******************************************************
   // Interrupt registers
   // ******************************************************
   // Brownout history resets to its idle low, so no false edge
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         irq_status <= 1'b0;
         irq_mask <= 1'b0;
         brownout_d <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         brownout_d <= i_brownout;
      end
   end

   // ******************************************************
   // Output registers
   // ******************************************************
   // Every port leaves a flip-flop; costs one cycle of latency, none for o_temp_sensor_en and o_io_mux_sel, loaded from next values
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_rdata <= 32'h0000_0000;
         o_irq <= 1'b0;
         o_temp_sensor_en <= 1'b0;
         o_share_switch_one <= 1'b0;
         o_share_switch_two <= 1'b0;
         o_io_mux_sel <= gmc_pkg::IO_MUX_RESET;
         o_per_in <= gmc_pkg::PIN_RESET;
      end else begin
         o_rdata <= next_rdata;
         o_irq <= next_irq;
         o_temp_sensor_en <= next_temp_en;
         o_share_switch_one <= next_sw1;
         o_share_switch_two <= next_sw2;
         o_io_mux_sel <= next_io_mux;
         o_per_in <= pin_level;
      end
   end

   // ******************************************************
   // Pin cells: only digital pins are listed, one per bit
   // ******************************************************
   genvar g;
   generate
      for (g = 0; g < gmc_pkg::NUM_PINS; g++) begin : g_pin // RL2
         gmc_pin_cell u_cell (
            .i_mclk(i_mclk),
            .i_reset(i_reset),
            .i_override(pin_override_register[g]), // RL15
            .i_glb_oe(pin_oe[g]),
            .i_glb_od(pin_open_drain[g]),
            .i_glb_value(pin_value[g]),
            .i_per_out(i_per_out[g]),
            .i_per_oe_n(i_per_oe_n[g]),
            .i_pin_in(i_pin_in[g]),
            .o_pin_out(o_pin_out[g]),
            .o_pin_oe_n(o_pin_oe_n[g]),
            .o_level(pin_level[g])
         ); // RL3
      end
   endgenerate

   // ******************************************************
   // Share PWM current source
   // ******************************************************
   gmc_share_pwm u_pwm (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_active(pwm_active),
      .i_period(share_period),
      .i_duty(share_duty),
      .o_pwm(o_share_pwm_output)
   ); // RL12
endmodule : gmc_top

//--- testbench/gmc_board.sv
// Board model of the shared digital pins
`timescale 1ns/10ps
module gmc_board (
   input wire logic [29:0] i_pin_out,
   input wire logic [29:0] i_pin_oe_n,
   input wire logic [29:0] i_ext_val,
   input wire logic [29:0] i_ext_en,
   output logic [29:0] o_level
);
   // ******************************
   // Wire resolution
   // ******************************
   // Released and undriven pins sit at the pull-up level
   always_comb begin
      o_level = (~i_pin_oe_n & i_pin_out) | (i_pin_oe_n & (~i_ext_en | i_ext_val));
   end
endmodule : gmc_board

//--- testbench/gmc_monitor.sv
// Port checker of the global I/O and misc control block
`timescale 1ns/10ps
module gmc_monitor (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_write,
   input wire logic i_read,
   input wire logic [31:0] o_rdata,
   input wire logic [29:0] i_per_out,
   input wire logic [29:0] i_per_oe_n,
   input wire logic [29:0] i_pin_in,
   input wire logic [29:0] o_pin_out,
   input wire logic [29:0] o_pin_oe_n,
   input wire logic [29:0] o_per_in,
   input wire logic i_brownout,
   input wire logic o_irq,
   input wire logic o_temp_sensor_en,
   input wire logic o_share_switch_one,
   input wire logic o_share_switch_two,
   input wire logic o_share_pwm_output
);
   // ******************************
   // Shadow state
   // ******************************
   logic [29:0] ov, oe, od, vl, eo, en;
   logic [1:0] md, age;
   logic mk, te;
   // Shadows of written fields; age holds back checks needing history
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         {ov, oe, od, vl, md, mk, te, age} <= '0;
      end else begin
         if (age != 2'h3) age <= age + 2'h1;
         if (i_write) begin
            case (i_addr)
               8'h00: ov <= i_wdata[29:0];
               8'h04: oe <= i_wdata[29:0];
               8'h08: od <= i_wdata[29:0];
               8'h0C: vl <= i_wdata[29:0];
               8'h18: te <= i_wdata[0];
               8'h1C: md <= i_wdata[1:0];
               8'h28: mk <= i_wdata[0];
               default: ;
            endcase
         end
      end
   end
   // Expected drive; open drain releases the pin for a one
   always_comb begin
      eo = (~ov & i_per_out) | (ov & oe & ~od & vl);
      en = (~ov & i_per_oe_n) | (ov & (~oe | (od & vl)));
   end
   // ******************************
   // Assertions
   // ******************************
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   // Sampled reset gate: the last reset edge still loads released pins
   a_pin_out_src: assert property (!i_reset |=> o_pin_out == $past(eo))
      else $error("pin output wrong");
   a_pin_dir_src: assert property (!i_reset |=> o_pin_oe_n == $past(en))
      else $error("pin enable wrong");
   a_switch_one: assert property (1 |=> o_share_switch_one == ($past(md) == 2'h1))
      else $error("switch one wrong");
   a_switch_two: assert property (1 |=> o_share_switch_two == ($past(md) == 2'h3))
      else $error("switch two wrong");
   a_pwm_idle: assert property ((md != 2'h1) [*3] |-> !o_share_pwm_output)
      else $error("pwm active off mode");
   a_irq_masked: assert property (!mk |=> !o_irq)
      else $error("masked irq raised");
   a_irq_raise: assert property ($rose(i_brownout) && mk |-> ##[1:3] o_irq)
      else $error("irq missing");
   a_read_idle: assert property (!i_read |=> o_rdata == 32'h0)
      else $error("rdata not idle");
   a_level_path: assert property (age == 2'h3 |-> o_per_in == $past(i_pin_in, 2))
      else $error("pin level path wrong");
   a_temp_ctrl: assert property (i_write && i_addr == 8'h18 |-> ##2 o_temp_sensor_en == te)
      else $error("sensor enable wrong");
   c_pwm: cover property (o_share_pwm_output);
   c_irq: cover property (o_irq);
   c_global: cover property (ov != 30'h0 && o_pin_oe_n != 30'h3FFFFFFF);
endmodule : gmc_monitor

bind gmc_top gmc_monitor u_mon (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
   .i_per_out(i_per_out), .i_per_oe_n(i_per_oe_n), .i_pin_in(i_pin_in),
   .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n), .o_per_in(o_per_in),
   .i_brownout(i_brownout), .o_irq(o_irq), .o_temp_sensor_en(o_temp_sensor_en),
   .o_share_switch_one(o_share_switch_one), .o_share_switch_two(o_share_switch_two),
   .o_share_pwm_output(o_share_pwm_output));

//--- testbench/tb.sv
// Self-checking bench of the global I/O and misc control block
`timescale 1ns/10ps
module tb;
   logic i_mclk, i_reset, i_write, i_read, i_brownout;
   logic rd_pend = 1'b0;
   logic [7:0] i_addr;
   logic [31:0] i_wdata, o_rdata, o_io_mux_sel, v;
   logic [29:0] i_per_out, i_per_oe_n, i_pin_in, o_pin_out, o_pin_oe_n, o_per_in;
   logic [29:0] ev, ee, ov, oe, od, vl, xo, xn, lv;
   logic o_irq, o_temp_sensor_en, o_share_switch_one, o_share_switch_two, o_share_pwm_output;
   logic [31:0] rq[$];
   logic [7:0] ra [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24,
      8'h28, 8'h2C, 8'h30};
   logic [31:0] rv [12] = '{0, 0, 0, 0, 0, 0, 32'h0000FF00, 32'h00000800, 0, 0, 0, 0};
   int mismatches, n_checks, hi;
   gmc_top uut (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_per_out(i_per_out),
      .i_per_oe_n(i_per_oe_n), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
      .o_pin_oe_n(o_pin_oe_n), .o_per_in(o_per_in), .i_brownout(i_brownout), .o_irq(o_irq),
      .o_temp_sensor_en(o_temp_sensor_en), .o_share_switch_one(o_share_switch_one),
      .o_share_switch_two(o_share_switch_two), .o_share_pwm_output(o_share_pwm_output),
      .o_io_mux_sel(o_io_mux_sel));
   gmc_board u_board (.i_pin_out(o_pin_out), .i_pin_oe_n(o_pin_oe_n), .i_ext_val(ev),
      .i_ext_en(ee), .o_level(i_pin_in));
   // ******************************
   // Tasks
   // ******************************
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Strobes drop for a cycle so no signal is set twice in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_write <= 1'b1;
      @(posedge i_mclk);
      i_write <= 1'b0;
      @(posedge i_mclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      i_addr <= a;
      i_read <= 1'b1;
      rq.push_back(e);
      @(posedge i_mclk);
      i_read <= 1'b0;
      @(posedge i_mclk);
   endtask : rd
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test
   // Read data stand one cycle only, so the oldest note is compared then
   always @(posedge i_mclk) begin
      if (rd_pend) chk("rdata", o_rdata, rq.pop_front());
      rd_pend <= i_read;
   end
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   // Hang guard, far above the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge i_mclk);
      mismatches++;
      finish_test();
   end
   // ******************************
   // Tests
   // ******************************
   initial begin
      {i_reset, i_write, i_read, i_brownout} = 4'b1000;
      {i_addr, i_wdata, i_per_out, i_per_oe_n, ev, ee} = '0;
      v = $urandom(32'h3F167710);
      repeat (6) @(posedge i_mclk);
      i_reset <= 1'b0;
      // Factory count is only read, never written
      foreach (ra[i]) rd(ra[i], rv[i]);
      chk("temp_en", 32'(o_temp_sensor_en), 0);
      $display("reset test done");
      repeat (3) begin
         i_per_out <= 30'($urandom);
         i_per_oe_n <= 30'($urandom);
         repeat (2) @(posedge i_mclk);
         chk("pin_out", 32'(o_pin_out), 32'(i_per_out));
         chk("pin_oe_n", 32'(o_pin_oe_n), 32'(i_per_oe_n));
      end
      $display("peripheral test done");
      repeat (4) begin
         ov = 30'($urandom);
         oe = 30'($urandom);
         od = 30'($urandom);
         vl = 30'($urandom);
         wr(8'h00, 32'(ov));
         wr(8'h04, 32'(oe));
         wr(8'h08, 32'(od));
         wr(8'h0C, 32'(vl));
         ev <= 30'($urandom);
         ee <= 30'($urandom);
         repeat (3) @(posedge i_mclk);
         xo = (~ov & i_per_out) | (ov & oe & ~od & vl);
         xn = (~ov & i_per_oe_n) | (ov & (~oe | (od & vl)));
         lv = (~xn & xo) | (xn & (~ee | ev));
         chk("pin_out", 32'(o_pin_out), 32'(xo));
         chk("pin_oe_n", 32'(o_pin_oe_n), 32'(xn));
         chk("per_in", 32'(o_per_in), 32'(lv));
         rd(8'h10, 32'(lv));
         rd(8'h00, 32'(ov));
      end
      $display("global pin test done");
      for (int p = 0; p < 4; p++) begin
         wr(8'h14, 32'(p));
         rd(8'h14, 32'(p));
      end
      for (int b = 1; b >= 0; b--) begin
         wr(8'h18, 32'(b));
         @(posedge i_mclk);
         chk("temp_en", 32'(o_temp_sensor_en), 32'(b));
      end
      $display("package and sensor test done");
      // Duty 4 of period 16 gives 8 high cycles in any 32
      for (int m = 0; m < 4; m++) begin
         wr(8'h1C, 32'h00040F00 | 32'(m));
         hi = 0;
         repeat (2) @(posedge i_mclk);
         repeat (32) begin
            @(posedge i_mclk);
            if (o_share_pwm_output === 1'b1) hi++;
         end
         chk("pwm_high", 32'(hi), (m == 1) ? 8 : 0);
         chk("switch_one", 32'(o_share_switch_one), 32'(m == 1));
         chk("switch_two", 32'(o_share_switch_two), 32'(m == 3));
         rd(8'h1C, 32'h00040F00 | 32'(m));
      end
      $display("share test done");
      wr(8'h28, 0);
      i_brownout <= 1'b1;
      repeat (3) @(posedge i_mclk);
      chk("irq", 32'(o_irq), 0);
      rd(8'h24, 1);
      wr(8'h28, 1);
      @(posedge i_mclk);
      chk("irq", 32'(o_irq), 1);
      wr(8'h24, 1);
      @(posedge i_mclk);
      chk("irq", 32'(o_irq), 0);
      rd(8'h24, 0);
      i_brownout <= 1'b0;
      @(posedge i_mclk);
      // Unmasked rising brownout raises the line on its own
      i_brownout <= 1'b1;
      repeat (3) @(posedge i_mclk);
      chk("irq", 32'(o_irq), 1);
      wr(8'h24, 1);
      i_brownout <= 1'b0;
      v = $urandom;
      wr(8'h2C, v);
      @(posedge i_mclk);
      chk("io_mux", o_io_mux_sel, v);
      rd(8'h2C, v);
      $display("irq and mux test done");
      finish_test();
   end
endmodule : tb
